//--- verification/iws_sequencer_chk.sv
// port assertions for the idle and wake sequencer
`timescale 1ns/10ps
module iws_sequencer_chk
    import iws_pkg::*;
#(
    parameter int RESTART_CYCLES = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // cpu side
    input wire logic idle_exec,
    input wire logic idle_paired,
    input wire logic isr_return,
    input wire logic wake_irq,
    input wire logic resume_at_idle,
    input wire logic cpu_halted,
    // clock controls
    input wire iws_busy_s port_busy,
    input wire iws_clk_s clk_en,
    input wire logic clkgen_keep
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // halted one cycle, running the next: the wake edge
    sequence s_wake;
        cpu_halted ##1 !cpu_halted;
    endsequence
    sequence s_restart;
        ##RESTART_CYCLES wake_irq;
    endsequence
    chk_idle_halts: assert property (idle_exec && !idle_paired && !cpu_halted |=> cpu_halted)
        else $error("idle did not halt");
    chk_paired_refused: assert property (idle_exec && idle_paired && !cpu_halted |=> !cpu_halted)
        else $error("paired idle halted");
    chk_mem_port_busy: assert property (cpu_halted && |port_busy && |$past(port_busy) |-> clk_en.mem_port)
        else $error("memory port gated while busy");
    chk_wake_restores: assert property (s_wake |-> clk_en == 6'h3F)
        else $error("clocks not restored on wake");
    chk_wake_irq_time: assert property (s_wake |-> s_restart)
        else $error("wake interrupt late or missing");
    chk_irq_single: assert property (wake_irq |=> !wake_irq)
        else $error("wake interrupt longer than one cycle");
    chk_resume_ret: assert property (isr_return |=> resume_at_idle)
        else $error("no resume after handler return");
    chk_clkgen_sleep: assert property (!clkgen_keep |-> cpu_halted)
        else $error("clock generator stopped while running");
endmodule
bind iws_sequencer iws_sequencer_chk #(.RESTART_CYCLES(RESTART_CYCLES)) u_chk (.*);

//--- verification/iws_sequencer_tb.sv
// self-checking bench for the idle and wake sequencer
`timescale 1ns/10ps
module iws_sequencer_tb
    import iws_pkg::*;
;
    logic ref_clk = 0;
    logic nrst = 0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic idle_exec = 0;
    logic idle_paired = 0;
    logic isr_return = 0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic [WAKE_N-1:0] wk = '0;
    iws_busy_s port_busy = '0;
    iws_clk_s clk_en;
    logic wake_irq, resume_at_idle, cpu_halted, clkgen_keep;
    int bad_count = 0;
    int comparisons = 0;
    int n;
    iws_sequencer u_dut (
        .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_exec(idle_exec),
        .idle_paired(idle_paired), .isr_return(isr_return), .wake_irq(wake_irq),
        .resume_at_idle(resume_at_idle), .cpu_halted(cpu_halted), .port_busy(port_busy),
        .wake_pin(wk[WK_PIN]), .rtc_irq(wk[WK_RTC]), .ext_irq0(wk[WK_EXT0]),
        .ext_irq1(wk[WK_EXT1]), .periph_irq(wk[WK_PERIPH]), .clk_en(clk_en),
        .clkgen_keep(clkgen_keep)
    );
    initial forever #2.5 ref_clk = ~ref_clk;
    task automatic tally_and_finish;
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata, e);
    endtask
    task automatic idle(input logic p);
        @(posedge ref_clk);
        idle_exec <= 1'b1;
        idle_paired <= p;
        tick(1);
        idle_exec <= 1'b0;
        idle_paired <= 1'b0;
    endtask
    // wake one source, then run the handler return
    task automatic wake(input logic [4:0] src);
        wk <= src;
        for (n = 0; n < 20 && cpu_halted !== 1'b0; n++) tick(1);
        cmp(16'(clk_en), 16'h003F);
        cmp(16'(clkgen_keep), 16'h0001);
        for (n = 0; n < 20 && wake_irq !== 1'b1; n++) tick(1);
        cmp(16'(wake_irq), 16'h0001);
        wk <= '0;
        @(posedge ref_clk);
        isr_return <= 1'b1;
        @(posedge ref_clk);
        isr_return <= 1'b0;
        #1 cmp(16'(resume_at_idle), 16'h0001);
    endtask
    initial begin
        #50000;
        bad_count++;
        tally_and_finish;
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        #1 cmp(16'(clk_en), 16'h003F);
        rd(ADR_STATUS, 16'h0001);
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'h0000);
        idle(1'b1);
        cmp(16'(cpu_halted), 16'h0000);
        rd(ADR_STATUS, 16'h8001);
        wr(ADR_STATUS, 16'h8000);
        rd(ADR_STATUS, 16'h0001);
        for (int i = 0; i < WAKE_N; i++) begin
            wr(ADR_IDLE_CFG, 16'h003F);
            wr(ADR_WAKE_EN, 16'(1 << i));
            idle(1'b0);
            rd(ADR_IDLE_STATE, 16'h003F);
            cmp(16'(clk_en), 16'h0000);
            wk <= 5'(1 << ((i + 1) % WAKE_N));
            tick(8);
            cmp(16'(cpu_halted), 16'h0001);
            wake(5'(1 << i));
            rd(ADR_IDLE_STATE, 16'h0000);
        end
        wr(ADR_IDLE_CFG, 16'h007F);
        wr(ADR_WAKE_EN, 16'h0001);
        port_busy.lcd <= 1'b1;
        idle(1'b0);
        cmp(16'(clk_en), 16'h0010);
        cmp(16'(clkgen_keep), 16'h0000);
        port_busy <= '0;
        tick(3);
        cmp(16'(clk_en), 16'h0000);
        wake(5'h01);
        rd(ADR_IDLE_STATE, 16'h0040);
        tick(4);
        idle(1'b0);
        nrst <= 1'b0;
        tick(2);
        cmp(16'(clk_en), 16'h003F);
        cmp(16'(cpu_halted), 16'h0000);
        nrst <= 1'b1;
        rd(ADR_IDLE_CFG, 16'h0000);
        rd(ADR_WAKE_EN, 16'h0000);
        tally_and_finish;
    end
endmodule

//--- verilog/iws_pkg.sv
// package: constants and types for the idle and wake sequencer
package iws_pkg;

    // idle configuration field positions
    localparam int CFG_W = 8;
    localparam int BIT_CPU = 0;
    localparam int BIT_MEM = 1;
    localparam int BIT_EXT = 2;
    localparam int BIT_DAT = 3;
    localparam int BIT_INS = 4;
    localparam int BIT_COP = 5;
    localparam int BIT_DEEP = 6;
    localparam logic [CFG_W-1:0] CPU_DOMAIN_MASK = 8'h3F;
    localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

    // register index map
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] ADR_IDLE_CFG = 4'h0;
    localparam logic [ADDR_W-1:0] ADR_IDLE_STATE = 4'h1;
    localparam logic [ADDR_W-1:0] ADR_WAKE_EN = 4'h2;
    localparam logic [ADDR_W-1:0] ADR_STATUS = 4'h3;

    // wake sources
    localparam int WAKE_N = 5;
    localparam int WK_PIN = 0;
    localparam int WK_RTC = 1;
    localparam int WK_EXT0 = 2;
    localparam int WK_EXT1 = 3;
    localparam int WK_PERIPH = 4;
    localparam logic [WAKE_N-1:0] WAKE_EN_RESET = 5'h00;

    // clock restart settle time before the service routine is fetched
    localparam int RESTART_NS = 20;
    localparam int CLK_PERIOD_NS = 5;
    localparam int RESTART_CYC = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        IWS_RUN = 4'b0001,
        IWS_SLEEP = 4'b0010,
        IWS_WAKE = 4'b0100,
        IWS_RESUME = 4'b1000
    } iws_state_e;

    // gated clock enables for the cpu domain
    typedef struct packed {
        logic cpu;
        logic mem_port;
        logic ext_port;
        logic data_port;
        logic instr_port;
        logic coproc;
    } iws_clk_s;

    // busy flags of the memory port masters
    typedef struct packed {
        logic usb_dma_engine;
        logic lcd;
        logic dma;
    } iws_busy_s;

endpackage

//--- verilog/iws_sequencer.sv
// idle entry and wake-up sequencer for the cpu clock domain
//
// What this block does
// - idle instruction copies configuration into status latch
// - status bits stop or run cpu-domain clocks
// - idle never issued paired with another instruction
// - memory port runs while dma masters busy
// - enabled wake interrupt restores cpu, runs handler
// - after handler, resume at the idle point
// - hardware reset ends idle, full reset
// - light sleep keeps clock generator and power on
// - accept pin, rtc, external, peripheral, reset wakes
`timescale 1ns/10ps
module iws_sequencer
    import iws_pkg::*;
#(
    parameter int RESTART_CYCLES = RESTART_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // cpu side
    input wire logic idle_exec,
    input wire logic idle_paired,
    input wire logic isr_return,
    output logic wake_irq,
    output logic resume_at_idle,
    output logic cpu_halted,
    // memory port masters, same clock
    input wire iws_busy_s port_busy,
    // wake sources from pins and other domains
    input wire logic wake_pin,
    input wire logic rtc_irq,
    input wire logic ext_irq0,
    input wire logic ext_irq1,
    input wire logic periph_irq,
    // clock domain controls
    output iws_clk_s clk_en,
    output logic clkgen_keep
);

    iws_state_e state;
    iws_state_e next_state;
    logic [CFG_W-1:0] idle_config_reg;
    logic [CFG_W-1:0] idle_state_latch;
    logic [WAKE_N-1:0] wake_en;
    logic [WAKE_N-1:0] wake_sync;
    logic [WAKE_N-1:0] wake_seen;
    logic [7:0] settle_cnt;
    logic paired_err;

    function automatic logic bit_on(input logic [CFG_W-1:0] v, input int idx);
        return v[idx];
    endfunction

    iws_sync #(
        .WIDTH(WAKE_N)
    ) u_wake_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .async_in({periph_irq, ext_irq1, ext_irq0, rtc_irq, wake_pin}),
        .sync_out(wake_sync)
    );

    // decode
    wire cfg_wr = reg_wr && (reg_addr == ADR_IDLE_CFG);
    wire en_wr = reg_wr && (reg_addr == ADR_WAKE_EN);
    wire idle_ok = idle_exec && !idle_paired;
    wire wake_hit = |(wake_sync & wake_en);
    wire in_run = (state == IWS_RUN);
    wire in_sleep = (state == IWS_SLEEP);
    wire take_idle = in_run && idle_ok;
    wire wake_now = in_sleep && wake_hit;
    wire settle_done = (settle_cnt == 8'(RESTART_CYCLES - 1));
    wire masters_busy = |port_busy;

    // state progression
    always_comb begin
        next_state = state;
        case (state)
            IWS_RUN: begin
                if (take_idle) begin
                    next_state = IWS_SLEEP;
                end
            end
            IWS_SLEEP: begin
                if (wake_hit) begin
                    next_state = IWS_WAKE;
                end
            end
            IWS_WAKE: begin
                if (settle_done) begin
                    next_state = IWS_RESUME;
                end
            end
            IWS_RESUME: begin
                if (isr_return) begin
                    next_state = IWS_RUN;
                end
            end
            default: begin
                next_state = IWS_RUN;
            end
        endcase
    end

    // status latch: loaded on idle, cpu bits cleared on wake
    wire [CFG_W-1:0] next_latch = take_idle ? idle_config_reg :
        wake_now ? (idle_state_latch & ~CPU_DOMAIN_MASK) : idle_state_latch;

    // clock enables from latch bits
    iws_clk_s next_clk_en;
    assign next_clk_en.cpu = !bit_on(next_latch, BIT_CPU);
    assign next_clk_en.mem_port = !bit_on(next_latch, BIT_MEM) || masters_busy;
    assign next_clk_en.ext_port = !bit_on(next_latch, BIT_EXT);
    assign next_clk_en.data_port = !bit_on(next_latch, BIT_DAT);
    assign next_clk_en.instr_port = !bit_on(next_latch, BIT_INS);
    assign next_clk_en.coproc = !bit_on(next_latch, BIT_COP);
    // light sleep leaves the generator running; deep sleep may drop it
    wire next_clkgen_keep = !(bit_on(next_latch, BIT_DEEP) && next_state == IWS_SLEEP);

    wire [WAKE_N-1:0] next_seen = wake_now ? (wake_sync & wake_en) : wake_seen;

    // read mux
    wire [DATA_W-1:0] rd_cfg = DATA_W'(idle_config_reg);
    wire [DATA_W-1:0] rd_state = DATA_W'(idle_state_latch);
    wire [DATA_W-1:0] rd_en = DATA_W'(wake_en);
    // sticky paired-idle error sits in the top bit, where software clears it
    wire [DATA_W-1:0] rd_stat = {
        paired_err,
        {(DATA_W - 1 - WAKE_N - $bits(iws_state_e)){1'b0}},
        wake_seen,
        state
    };
    wire [DATA_W-1:0] next_rdata = !reg_rd ? '0 :
        (reg_addr == ADR_IDLE_CFG) ? rd_cfg :
        (reg_addr == ADR_IDLE_STATE) ? rd_state :
        (reg_addr == ADR_WAKE_EN) ? rd_en :
        (reg_addr == ADR_STATUS) ? rd_stat : '0;

    // hardware reset clears the registers but enables every clock, nothing survives from before idle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= IWS_RUN;
            idle_config_reg <= CFG_RESET;
            idle_state_latch <= CFG_RESET;
            wake_en <= WAKE_EN_RESET;
            wake_seen <= '0;
            clk_en <= '1;
            clkgen_keep <= 1'b1;
            reg_rdata <= '0;
        end else begin
            state <= next_state;
            idle_state_latch <= next_latch;
            clk_en <= next_clk_en;
            clkgen_keep <= next_clkgen_keep;
            wake_seen <= next_seen;
            reg_rdata <= next_rdata;
            if (cfg_wr) begin
                idle_config_reg <= reg_wdata[CFG_W-1:0];
            end
            if (en_wr) begin
                wake_en <= reg_wdata[WAKE_N-1:0];
            end
        end
    end

    // settle counter, paired-idle sticky error, cpu handshakes
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            settle_cnt <= '0;
            paired_err <= 1'b0;
            wake_irq <= 1'b0;
            resume_at_idle <= 1'b0;
            cpu_halted <= 1'b0;
        end else begin
            settle_cnt <= (state == IWS_WAKE && !settle_done) ? settle_cnt + 8'd1 : '0;
            // set wins over a clear written in the same cycle
            if (in_run && idle_exec && idle_paired) begin
                paired_err <= 1'b1;
            end else if (reg_wr && reg_addr == ADR_STATUS && reg_wdata[DATA_W-1]) begin
                paired_err <= 1'b0;
            end
            wake_irq <= (state == IWS_WAKE) && settle_done;
            resume_at_idle <= (state == IWS_RESUME) && isr_return;
            cpu_halted <= (next_state == IWS_SLEEP);
        end
    end

endmodule

//--- verilog/iws_sync.sv
// three-stage synchroniser with agree filter for asynchronous wake inputs
`timescale 1ns/10ps
module iws_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
    wire [WIDTH-1:0] next_sync_out = (agree & stage2) | (~agree & sync_out);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            sync_out <= next_sync_out;
        end
    end
endmodule
